/* File: design/nibble_bus_pkg.sv */
// constants and carrier types for the nibble host port
package nibble_bus_pkg;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned DEPTH = 16;
  localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 4'h0;
  localparam logic SEL_LOW_RESET = 1'b1;

  // raw host pins after synchronisation
  typedef struct packed {
    logic [IDX_W-1:0] reg_index;
    logic [DATA_W-1:0] data_nibble;
    logic select_low_active;
    logic select_power_good;
    logic latch_strobe;
    logic rd_n;
    logic wr_n;
  } pins_type;

  // access to the location store
  typedef struct packed {
    logic we;
    logic [IDX_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_type;
endpackage

/* File: design/nibble_store.sv */
// sixteen-location nibble store with registered read data
`timescale 1ns/10ps
`default_nettype none
module nibble_store (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire nibble_bus_pkg::mem_req_type req_i,
  output logic [nibble_bus_pkg::DATA_W-1:0] rdata_o
);
  logic [nibble_bus_pkg::DATA_W-1:0] mem_r [nibble_bus_pkg::DEPTH];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < nibble_bus_pkg::DEPTH; i++) begin
        mem_r[i] <= nibble_bus_pkg::DATA_RESET;
      end
    end else if (req_i.we) begin
      mem_r[req_i.addr] <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= nibble_bus_pkg::DATA_RESET;
    end else begin
      rdata_o <= mem_r[req_i.addr];
    end
  end
endmodule // nibble_store
`default_nettype wire

/* File: design/nibble_host_port.sv */
// asynchronous 4-bit host port: address latch, strobes, data bus drive
`timescale 1ns/10ps
`default_nettype none
// Operation
// - latch strobe high lets address and low select flow into latch.
// - falling latch strobe captures address and low select, held while low.
// - four address inputs choose the accessed location.
// - active write strobe edge stores bus nibble at selected location.
// - read strobe low with chip selected drives stored nibble out.
// - access only with power select high and low select low.
// - power select low means standby, bus access blocked.
// - power select low keeps data bus high impedance always.
module nibble_host_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_index_i,
  input wire logic [3:0] data_nibble_i,
  input wire logic select_low_active_n_i,
  input wire logic select_power_good_i,
  input wire logic latch_strobe_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic [3:0] data_nibble_o,
  output logic [3:0] data_nibble_oe_o,
  output logic standby_o
);
  // ==========================================================
  // pin synchronisers
  nibble_bus_pkg::pins_type pins_s1_r;
  nibble_bus_pkg::pins_type pins_r;
  nibble_bus_pkg::pins_type pins_in;

  always_comb begin
    pins_in.reg_index = reg_index_i;
    pins_in.data_nibble = data_nibble_i;
    pins_in.select_low_active = select_low_active_n_i;
    pins_in.select_power_good = select_power_good_i;
    pins_in.latch_strobe = latch_strobe_i;
    pins_in.rd_n = rd_n_i;
    pins_in.wr_n = wr_n_i;
  end

  // first stage: read by the second stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_s1_r <= '1;
    end else begin
      pins_s1_r <= pins_in;
    end
  end

  // second stage: the only copy the logic reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_r <= '1;
    end else begin
      pins_r <= pins_s1_r;
    end
  end

  // ==========================================================
  // address latch
  logic [nibble_bus_pkg::IDX_W-1:0] idx_r;
  logic sel_low_r;

  // index follows the pins while the strobe is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_r <= nibble_bus_pkg::IDX_RESET;
    end else if (pins_r.latch_strobe) begin
      idx_r <= pins_r.reg_index;
    end else begin
      idx_r <= idx_r;
    end
  end

  // low select follows the pin in the same way
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_low_r <= nibble_bus_pkg::SEL_LOW_RESET;
    end else if (pins_r.latch_strobe) begin
      sel_low_r <= pins_r.select_low_active;
    end else begin
      sel_low_r <= sel_low_r;
    end
  end

  // transparent path so a tied-high strobe adds no latency
  logic [nibble_bus_pkg::IDX_W-1:0] idx_eff;
  logic sel_low_eff;
  assign idx_eff = pins_r.latch_strobe ? pins_r.reg_index : idx_r;
  assign sel_low_eff = pins_r.latch_strobe ? pins_r.select_low_active
                                           : sel_low_r;

  // ==========================================================
  // selection and strobes
  logic selected;
  logic wr_prev_r;
  logic wr_fall;
  logic rd_active;
  logic wr_accept;

  assign selected = pins_r.select_power_good & ~sel_low_eff;
  assign rd_active = selected & ~pins_r.rd_n & pins_r.wr_n;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_prev_r <= 1'b1;
    end else begin
      wr_prev_r <= pins_r.wr_n;
    end
  end

  assign wr_fall = wr_prev_r & ~pins_r.wr_n;
  // both strobes low is refused
  assign wr_accept = wr_fall & selected & pins_r.rd_n;

  // ==========================================================
  // access sequencer
  typedef enum logic [1:0] {
    ACC_IDLE = 2'h0,
    ACC_READ_SETTLE = 2'h1,
    ACC_READ_DRIVE = 2'h2,
    ACC_STANDBY = 2'h3
  } access_state_type;

  access_state_type state_r;
  access_state_type state_nxt;
  logic reading;
  logic drive_ok;

  // read checked first in every state: read states mean read last cycle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACC_IDLE: begin
        if (rd_active) begin
          state_nxt = ACC_READ_SETTLE;
        end else if (!pins_r.select_power_good) begin
          state_nxt = ACC_STANDBY;
        end
      end
      ACC_READ_SETTLE: begin
        if (rd_active) begin
          state_nxt = ACC_READ_DRIVE;
        end else if (!pins_r.select_power_good) begin
          state_nxt = ACC_STANDBY;
        end else begin
          state_nxt = ACC_IDLE;
        end
      end
      ACC_READ_DRIVE: begin
        if (rd_active) begin
          state_nxt = ACC_READ_DRIVE;
        end else if (!pins_r.select_power_good) begin
          state_nxt = ACC_STANDBY;
        end else begin
          state_nxt = ACC_IDLE;
        end
      end
      ACC_STANDBY: begin
        if (rd_active) begin
          state_nxt = ACC_READ_SETTLE;
        end else if (pins_r.select_power_good) begin
          state_nxt = ACC_IDLE;
        end
      end
      default: begin
        state_nxt = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ACC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reading = (state_r == ACC_READ_SETTLE) |
                   (state_r == ACC_READ_DRIVE);
  assign drive_ok = rd_active & reading;

  // ==========================================================
  // location store
  nibble_bus_pkg::mem_req_type req;
  logic [nibble_bus_pkg::DATA_W-1:0] rdata;

  always_comb begin
    req.we = wr_accept;
    req.addr = idx_eff;
    req.wdata = pins_r.data_nibble;
  end

  nibble_store u_nibble_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(req),
    .rdata_o(rdata)
  );

  // ==========================================================
  // data bus drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_nibble_o <= nibble_bus_pkg::DATA_RESET;
    end else begin
      data_nibble_o <= rdata;
    end
  end

  // enable needs read held a cycle so store data is settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_nibble_oe_o <= '0;
    end else begin
      data_nibble_oe_o <= {nibble_bus_pkg::DATA_W{drive_ok}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby_o <= 1'b0;
    end else begin
      standby_o <= (state_nxt == ACC_STANDBY);
    end
  end
endmodule // nibble_host_port
`default_nettype wire

/* File: sim/nibble_host_port_asserts.sv */
// assertions on the nibble host port pins
`timescale 1ns/10ps
`default_nettype none
module nibble_host_port_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic select_low_active_n_i,
  input wire logic select_power_good_i,
  input wire logic latch_strobe_i,
  input wire logic rd_n_i,
  input wire logic [3:0] data_nibble_oe_o,
  input wire logic standby_o
);
  // low select as the address latch should be holding it
  logic sel_held_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_held_r <= 1'b1;
    end else if (latch_strobe_i) begin
      sel_held_r <= select_low_active_n_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_sb; !select_power_good_i [*5] |-> standby_o; endproperty
  a_sb: assert property (p_sb) else $error("no standby");
  property p_hz; !select_power_good_i [*4] |-> !data_nibble_oe_o; endproperty
  a_hz: assert property (p_hz) else $error("bus driven");
  property p_rd; |data_nibble_oe_o |-> !$past(rd_n_i, 3); endproperty
  a_rd: assert property (p_rd) else $error("drive no read");
  property p_fl; data_nibble_oe_o inside {4'h0, 4'hf}; endproperty
  a_fl: assert property (p_fl) else $error("part drive");
  property p_on; (!rd_n_i && select_power_good_i && latch_strobe_i &&
    !select_low_active_n_i) [*6] |-> &data_nibble_oe_o; endproperty
  a_on: assert property (p_on) else $error("no read drive");
  property p_off; (latch_strobe_i && select_low_active_n_i) [*6]
    |-> !data_nibble_oe_o; endproperty
  a_off: assert property (p_off) else $error("unselected");
  property p_lh; (!latch_strobe_i && !sel_held_r && !rd_n_i &&
    select_power_good_i) [*6] |-> &data_nibble_oe_o; endproperty
  a_lh: assert property (p_lh) else $error("latch moved");
  property p_rs; $fell(rst_i) |-> !data_nibble_oe_o && !standby_o; endproperty
  a_rs: assert property (p_rs) else $error("reset drive");
  c_rd: cover property (&data_nibble_oe_o);
  c_sb: cover property (standby_o);
  c_lt: cover property ($fell(latch_strobe_i));
endmodule // nibble_host_port_asserts
bind nibble_host_port nibble_host_port_asserts u_nibble_host_port_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .select_low_active_n_i(select_low_active_n_i),
  .select_power_good_i(select_power_good_i), .latch_strobe_i(latch_strobe_i),
  .rd_n_i(rd_n_i), .data_nibble_oe_o(data_nibble_oe_o), .standby_o(standby_o));
`default_nettype wire

/* File: sim/host_model.sv */
// host processor model driving the port pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic [3:0] bus_i,
  output var nibble_bus_pkg::pins_type p_o
);
  initial p_o = '{reg_index: 4'h0, data_nibble: 4'h0, select_low_active: 1'b0,
    select_power_good: 1'b1, latch_strobe: 1'b1, rd_n: 1'b1,
    wr_n: 1'b1};
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge clk_i);
    p_o.reg_index <= a;
    p_o.data_nibble <= d;
    p_o.wr_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    p_o.wr_n <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [3:0] q);
    @(posedge clk_i);
    p_o.reg_index <= a;
    p_o.data_nibble <= ~p_o.data_nibble;
    p_o.rd_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    q = bus_i;
    p_o.rd_n <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // host_model
`default_nettype wire

/* File: sim/rtc_nibble_bus_interface_bench.sv */
// bench for the nibble host port
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module rtc_nibble_bus_interface_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  int n_mismatch = 0;
  int checked = 0;
  logic [3:0] q, dout, oe;
  logic sb;
  wire [3:0] bus;
  nibble_bus_pkg::pins_type p;
  assign bus = (dout & oe) | (p.data_nibble & ~oe);
  host_model u_host_model (.clk_i(clk_i), .bus_i(bus), .p_o(p));
  nibble_host_port u_nibble_host_port (.clk_i(clk_i), .rst_i(rst_i),
    .reg_index_i(p.reg_index), .data_nibble_i(bus), .rd_n_i(p.rd_n),
    .select_low_active_n_i(p.select_low_active), .wr_n_i(p.wr_n),
    .select_power_good_i(p.select_power_good), .standby_o(sb),
    .latch_strobe_i(p.latch_strobe), .data_nibble_o(dout),
    .data_nibble_oe_o(oe));
  initial forever #2 clk_i = ~clk_i;
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_rw;
    for (int i = 0; i < 16; i++) u_host_model.wr(4'(i), 4'(~i));
    for (int i = 0; i < 16; i++) begin
      u_host_model.rd(4'(i), q);
      `CHK("read", 4'(~i), q)
    end
  endtask
  task automatic t_ref;
    u_host_model.p_o.select_low_active <= 1'b1;
    u_host_model.wr(4'h3, 4'h9);
    u_host_model.p_o.select_low_active <= 1'b0;
    u_host_model.rd(4'h3, q);
    `CHK("refused", 4'hc, q)
  endtask
  task automatic t_sb;
    u_host_model.p_o.select_power_good <= 1'b0;
    u_host_model.wr(4'h4, 4'h6);
    `CHK("standby", 1'b1, sb)
    u_host_model.rd(4'h4, q);
    `CHK("floated", 4'h9, q)
    u_host_model.p_o.select_power_good <= 1'b1;
    u_host_model.rd(4'h4, q);
    `CHK("blocked", 4'hb, q)
    `CHK("awake", 1'b0, sb)
  endtask
  task automatic t_lat;
    u_host_model.p_o.reg_index <= 4'h2;
    repeat (4) @(posedge clk_i);
    u_host_model.p_o.latch_strobe <= 1'b0;
    u_host_model.wr(4'h7, 4'h1);
    u_host_model.rd(4'h7, q);
    `CHK("held", 4'h1, q)
    u_host_model.p_o.select_low_active <= 1'b1;
    u_host_model.wr(4'h7, 4'h5);
    u_host_model.rd(4'h7, q);
    `CHK("held select", 4'h5, q)
    u_host_model.p_o.select_low_active <= 1'b0;
    u_host_model.p_o.latch_strobe <= 1'b1;
    u_host_model.rd(4'h7, q);
    `CHK("open", 4'h8, q)
    u_host_model.rd(4'h2, q);
    `CHK("latched slot", 4'h5, q)
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rw;
    t_ref;
    t_sb;
    t_lat;
    stop_test;
  end
  initial begin
    #20000;
    n_mismatch++;
    stop_test;
  end
endmodule // rtc_nibble_bus_interface_bench
`default_nettype wire
